// ### hw/rss_top.sv
`timescale 1ns/1ps
`default_nettype none
module rss_top
  import rss_pkg::*;
(
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_B_I,
  input  wire logic [11:0] ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [31:0] RDATA_O,
  input  wire logic        SIG_VALID_I,
  input  wire logic [4:0]  SIG_SLOT_I,
  input  wire logic [3:0]  SIG_ABCD_I,
  output logic             RX_SIG_VALID_O,
  output logic      [4:0]  RX_SIG_SLOT_O,
  output logic      [3:0]  RX_SIG_DATA_O,
  output logic             RX_OVERHEAD_OUTPUT_O
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic       rst_b;

  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      rst_sync_ff <= 2'b00;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_b = rst_sync_ff[1];

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic       hit_sub;
  logic       hit_arr;
  logic       hit_cfg;
  logic [4:0] idx;

  always_comb
  begin
    hit_sub = (ADDR_I >= SUBST_BASE) && (ADDR_I <= SUBST_LAST);
    hit_arr = (ADDR_I >= ARRAY_BASE) && (ADDR_I <= ARRAY_LAST);
    hit_cfg = (ADDR_I >= CFG_BASE) && (ADDR_I <= CFG_LAST);
    idx     = ADDR_I[4:0];
  end

  // ---------------------------------------------------------------
  // substitute value bank, one byte per timeslot
  // ---------------------------------------------------------------
  logic [7:0] sub_rd;
  logic [7:0] sub_lk;

  rss_mem #(
    .DEPTH (32),
    .WIDTH (8),
    .AW    (5)
  ) u_subst (
    .clk_i     (REF_CLK_I),
    .rst_b_i   (rst_b),
    .wr_en_i   (WR_I && hit_sub),                      // RL9
    .wr_addr_i (idx),
    .wr_data_i ({1'b0, WDATA_I[6:0]}),
    .rd_addr_i (idx),
    .rd_data_o (sub_rd),
    .lk_addr_i (SIG_SLOT_I),
    .lk_data_o (sub_lk)
  );

  // ---------------------------------------------------------------
  // per-slot config and signaling array
  // ---------------------------------------------------------------
  logic [4:0] cfg_ff  [32];
  logic [4:0] nxt_cfg [32];
  logic [3:0] arr_ff  [32];
  logic [3:0] nxt_arr [32];

  // stage 1 holds the incoming symbol while the bank lookup settles
  rss_sig_s   stg_ff;
  rss_sig_s   nxt_stg;
  logic       ext;
  logic [3:0] abcd;
  logic [4:0] scfg;

  always_comb
  begin
    nxt_stg.valid = SIG_VALID_I;
    nxt_stg.slot  = SIG_SLOT_I;
    nxt_stg.abcd  = SIG_ABCD_I;
    scfg = cfg_ff[stg_ff.slot];
  end

  rss_slot_proc u_proc (
    .rx_abcd_i (stg_ff.abcd),
    .ext_sel_i (scfg[EXT_LSB +: 2]),
    .sub_sel_i (scfg[SUB_LSB +: 2]),
    .subst_i   (sub_lk),
    .extract_o (ext),
    .abcd_o    (abcd)
  );

  genvar g;
  generate
    for (g = 0; g < 32; g++)
    begin : g_slot
      always_comb
      begin
        nxt_cfg[g] = cfg_ff[g];
        nxt_arr[g] = arr_ff[g];
        if (WR_I && hit_cfg && (idx == 5'(g)))
          nxt_cfg[g] = WDATA_I[4:0];
        if (stg_ff.valid && ext && (stg_ff.slot == 5'(g)))
          nxt_arr[g] = abcd;                           // RL5
      end
      always_ff @(posedge REF_CLK_I or negedge rst_b)
      begin
        if (!rst_b)
        begin
          cfg_ff[g] <= 5'(CFG_RESET);
          arr_ff[g] <= 4'h0;
        end
        else
        begin
          cfg_ff[g] <= nxt_cfg[g];
          arr_ff[g] <= nxt_arr[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // outputs and read data
  // ---------------------------------------------------------------
  logic        rd_d_ff;
  logic [1:0]  rd_sel_ff;
  logic [31:0] rd_reg_ff;
  logic [31:0] nxt_rd_reg;
  logic        nxt_vld;
  logic        nxt_oh;

  always_comb
  begin
    nxt_rd_reg = 32'h0;
    if (RD_I && hit_arr)
      nxt_rd_reg = {28'h0, arr_ff[idx]};
    else if (RD_I && hit_cfg)
      nxt_rd_reg = {27'h0, cfg_ff[idx]};
    nxt_vld = stg_ff.valid && ext;                     // RL5
    nxt_oh  = nxt_vld && scfg[OH_EN_POS];              // RL5
  end

  always_ff @(posedge REF_CLK_I or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stg_ff               <= '0;
      rd_d_ff              <= 1'b0;
      rd_sel_ff            <= 2'b00;
      rd_reg_ff            <= 32'h0;
      RX_SIG_VALID_O       <= 1'b0;
      RX_SIG_SLOT_O        <= 5'h00;
      RX_SIG_DATA_O        <= 4'h0;
      RX_OVERHEAD_OUTPUT_O <= 1'b0;
    end
    else
    begin
      stg_ff               <= nxt_stg;
      rd_d_ff              <= RD_I;
      rd_sel_ff            <= {RD_I && hit_sub, 1'b0};
      rd_reg_ff            <= nxt_rd_reg;
      RX_SIG_VALID_O       <= nxt_vld;
      RX_SIG_SLOT_O        <= stg_ff.slot;
      RX_SIG_DATA_O        <= abcd;
      RX_OVERHEAD_OUTPUT_O <= nxt_oh;
    end
  end

  // bank data is registered in the memory, the rest here; mux the two
  always_comb
  begin
    RDATA_O = rd_reg_ff;
    if (rd_d_ff && rd_sel_ff[1])
      RDATA_O = {24'h0, sub_rd};
  end

endmodule // rss_top
`default_nettype wire

// ### hw/rss_pkg.sv
// Contract
// [RL1] select 01 extracts all four signaling bits A, B, C, D
// [RL2] select 10 extracts only bits A and B, C and D ignored
// [RL3] select 11 extracts only bit A
// [RL4] select 00 extracts nothing from that timeslot
// [RL5] extracted bits go to array registers, signaling output, overhead output if enabled
// [RL6] 2-code substitution replaces A with substitute register bit 6
// [RL7] 4-code substitution replaces B with bit 5 and A with bit 4
// [RL8] 16-code substitution replaces D, C, B, A with bits 3, 2, 1, 0
// [RL9] 32 read/write substitute registers, lowest address slot 0, reset zero
// [RL10] substitution disabled passes received bits unchanged
package rss_pkg;

  // ---------------------------------------------------------------
  // register map (word addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [11:0] SUBST_BASE    = 12'h3C0;
  localparam logic [11:0] SUBST_LAST    = 12'h3DF;
  localparam logic [11:0] ARRAY_BASE    = 12'h500;
  localparam logic [11:0] ARRAY_LAST    = 12'h51F;
  localparam logic [11:0] CFG_BASE      = 12'h600;
  localparam logic [11:0] CFG_LAST      = 12'h61F;
  localparam logic [7:0]  SUBST_RESET   = 8'h00;
  localparam logic [7:0]  CFG_RESET     = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int TWO_A_POS     = 6;
  localparam int FOUR_B_POS    = 5;
  localparam int FOUR_A_POS    = 4;
  localparam int SIXTEEN_D_POS = 3;
  localparam int SIXTEEN_C_POS = 2;
  localparam int SIXTEEN_B_POS = 1;
  localparam int SIXTEEN_A_POS = 0;
  // config register: [1:0] extract select, [3:2] substitute select
  localparam int EXT_LSB       = 0;
  localparam int SUB_LSB       = 2;
  localparam int OH_EN_POS     = 4;

  typedef enum logic [1:0] {
    EXT_NONE = 2'b00,
    EXT_ABCD = 2'b01,
    EXT_AB   = 2'b10,
    EXT_A    = 2'b11
  } rss_ext_e;

  typedef enum logic [1:0] {
    SUB_OFF     = 2'b00,
    SUB_TWO     = 2'b01,
    SUB_FOUR    = 2'b10,
    SUB_SIXTEEN = 2'b11
  } rss_sub_e;

  // signaling nibble is {A,B,C,D}, A in bit 3 as in the array register
  typedef struct packed {
    logic       valid;
    logic [4:0] slot;
    logic [3:0] abcd;
  } rss_sig_s;

endpackage : rss_pkg

// ### hw/rss_mem.sv
`timescale 1ns/1ps
`default_nettype none
module rss_mem
  import rss_pkg::*;
#(
  parameter int DEPTH = 32,
  parameter int WIDTH = 8,
  parameter int AW    = 5
)(
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic [AW-1:0]    rd_addr_i,
  output logic      [WIDTH-1:0] rd_data_o,
  input  wire logic [AW-1:0]    lk_addr_i,
  output logic      [WIDTH-1:0] lk_data_o
);

  // ---------------------------------------------------------------
  // storage: registers so every entry has a reset value
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] nxt_mem [DEPTH];
  logic [WIDTH-1:0] nxt_rd;
  logic [WIDTH-1:0] nxt_lk;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_ent
      always_comb
      begin
        nxt_mem[g] = mem_ff[g];
        if (wr_en_i && (wr_addr_i == AW'(g)))
          nxt_mem[g] = wr_data_i;
      end
      always_ff @(posedge clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
          mem_ff[g] <= '0;
        else
          mem_ff[g] <= nxt_mem[g];
      end
    end
  endgenerate

  always_comb
  begin
    nxt_rd = mem_ff[rd_addr_i];
    nxt_lk = mem_ff[lk_addr_i];
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_data_o <= '0;
      lk_data_o <= '0;
    end
    else
    begin
      rd_data_o <= nxt_rd;
      lk_data_o <= nxt_lk;
    end
  end

endmodule // rss_mem
`default_nettype wire

// ### hw/rss_slot_proc.sv
`timescale 1ns/1ps
`default_nettype none
module rss_slot_proc
  import rss_pkg::*;
(
  input  wire logic [3:0] rx_abcd_i,
  input  wire logic [1:0] ext_sel_i,
  input  wire logic [1:0] sub_sel_i,
  input  wire logic [7:0] subst_i,
  output logic            extract_o,
  output logic      [3:0] abcd_o
);

  // ---------------------------------------------------------------
  // substitution then extraction mask
  // ---------------------------------------------------------------
  logic [3:0] sub;

  always_comb
  begin
    sub = rx_abcd_i;                                   // RL10
    case (rss_sub_e'(sub_sel_i))
      SUB_OFF:     sub = rx_abcd_i;                    // RL10
      SUB_TWO:     sub[3] = subst_i[TWO_A_POS];        // RL6
      SUB_FOUR:                                        // RL7
      begin
        sub[3] = subst_i[FOUR_A_POS];
        sub[2] = subst_i[FOUR_B_POS];
      end
      SUB_SIXTEEN:                                     // RL8
      begin
        sub[3] = subst_i[SIXTEEN_A_POS];
        sub[2] = subst_i[SIXTEEN_B_POS];
        sub[1] = subst_i[SIXTEEN_C_POS];
        sub[0] = subst_i[SIXTEEN_D_POS];
      end
      default:     sub = rx_abcd_i;
    endcase
    // unextracted bits read as zero so stale values never leak out
    extract_o = 1'b1;
    abcd_o    = 4'h0;
    case (rss_ext_e'(ext_sel_i))
      EXT_NONE: extract_o = 1'b0;                      // RL4
      EXT_ABCD: abcd_o = sub;                          // RL1
      EXT_AB:   abcd_o = {sub[3:2], 2'b00};            // RL2
      EXT_A:    abcd_o = {sub[3], 3'b000};             // RL3
      default:  extract_o = 1'b0;
    endcase
  end

endmodule // rss_slot_proc
`default_nettype wire

// ### tb/rss_framer_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// receive framer stream: one symbol per go
// ---------------------------------------------
module rss_framer_model
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       go_i,
  input  wire logic [4:0] slot_i,
  input  wire logic [3:0] abcd_i,
  output logic            valid_o,
  output logic      [4:0] slot_o,
  output logic      [3:0] abcd_o
);
  // idle lines flip so a stale value never looks like a symbol
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      valid_o <= 1'b0;
      slot_o  <= 5'h00;
      abcd_o  <= 4'h0;
    end
    else
    begin
      valid_o <= go_i;
      slot_o  <= go_i ? slot_i : ~slot_o;
      abcd_o  <= go_i ? abcd_i : ~abcd_o;
    end
endmodule // rss_framer_model
`default_nettype wire

// ### tb/rss_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rss_monitor
  import rss_pkg::*;
(
  input wire logic        REF_CLK_I,
  input wire logic        RST_B_I,
  input wire logic [11:0] ADDR_I,
  input wire logic        RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic        SIG_VALID_I,
  input wire logic [4:0]  SIG_SLOT_I,
  input wire logic        RX_SIG_VALID_O,
  input wire logic [4:0]  RX_SIG_SLOT_O,
  input wire logic        RX_OVERHEAD_OUTPUT_O
);
  logic bank, arr, cfg;
  assign bank = ADDR_I >= SUBST_BASE && ADDR_I <= SUBST_LAST;
  assign arr  = ADDR_I >= ARRAY_BASE && ADDR_I <= ARRAY_LAST;
  assign cfg  = ADDR_I >= CFG_BASE && ADDR_I <= CFG_LAST;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);
  // ---------------------------------------------
  // register port
  // ---------------------------------------------
  a_read_idle: assert property (
    !$past(RD_I) |-> RDATA_O == 32'h0) else $error("data off slot");
  a_unmapped_zero: assert property (
    $past(RD_I) && !$past(bank || arr || cfg) |-> RDATA_O == 32'h0)
    else $error("unmapped read not zero");
  a_bank_width: assert property (
    $past(RD_I) && $past(bank) |-> RDATA_O[31:7] == 25'h0)
    else $error("bank read too wide");
  a_cfg_width: assert property (
    $past(RD_I) && $past(cfg) |-> RDATA_O[31:5] == 27'h0)
    else $error("cfg read too wide");
  a_array_width: assert property (
    $past(RD_I) && $past(arr) |-> RDATA_O[31:4] == 28'h0)
    else $error("array read too wide");
  // ---------------------------------------------
  // signaling stream
  // ---------------------------------------------
  a_out_latency: assert property (
    RX_SIG_VALID_O |-> $past(SIG_VALID_I, 2)) else $error("stray out");
  a_slot_follow: assert property (
    RX_SIG_VALID_O |-> RX_SIG_SLOT_O == $past(SIG_SLOT_I, 2))
    else $error("slot mismatch");
  a_oh_with_sig: assert property (
    RX_OVERHEAD_OUTPUT_O |-> RX_SIG_VALID_O) else $error("lone oh");
endmodule // rss_monitor
bind rss_top rss_monitor rss_monitor_i (.REF_CLK_I(REF_CLK_I),
  .RST_B_I(RST_B_I), .ADDR_I(ADDR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .SIG_VALID_I(SIG_VALID_I), .SIG_SLOT_I(SIG_SLOT_I),
  .RX_SIG_VALID_O(RX_SIG_VALID_O), .RX_SIG_SLOT_O(RX_SIG_SLOT_O),
  .RX_OVERHEAD_OUTPUT_O(RX_OVERHEAD_OUTPUT_O));
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import rss_pkg::*;;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [4:0]  pslot = 5'h00, sslot, oslot;
  logic [3:0]  pabcd = 4'h0, sabcd, odata;
  logic        svalid, ovalid, ooh;
  int mismatches = 0, samples_checked = 0;
  always #5 clk = ~clk;
  rss_framer_model rss_framer_model_i (.clk_i(clk), .rst_b_i(rst_b),
    .go_i(go), .slot_i(pslot), .abcd_i(pabcd), .valid_o(svalid),
    .slot_o(sslot), .abcd_o(sabcd));
  rss_top rss_top_i (.REF_CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .SIG_VALID_I(svalid), .SIG_SLOT_I(sslot), .SIG_ABCD_I(sabcd),
    .RX_SIG_VALID_O(ovalid), .RX_SIG_SLOT_O(oslot),
    .RX_SIG_DATA_O(odata), .RX_OVERHEAD_OUTPUT_O(ooh));
  // ---------------------------------------------
  // access tasks
  // ---------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 cmp(rdata, exp);
  endtask
  // output launches three edges after go: model, take, out; it stands
  // for one cycle only, so look right after that third edge
  task automatic send(input logic [4:0] t, input logic [3:0] r);
    @(posedge clk);
    go    <= 1'b1;
    pslot <= t;
    pabcd <= r;
    @(posedge clk);
    go    <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  function automatic logic [3:0] exp_sig(input logic [3:0] r,
    input logic [1:0] e, input logic [1:0] c, input logic [7:0] s);
    logic [3:0] x;
    x = r;
    if (c == SUB_TWO) x[3] = s[TWO_A_POS];
    if (c == SUB_FOUR) x[3:2] = {s[FOUR_A_POS], s[FOUR_B_POS]};
    if (c == SUB_SIXTEEN) x = {s[0], s[1], s[2], s[3]};
    if (e == EXT_AB) x[1:0] = 2'h0;
    if (e == EXT_A) x[2:0] = 3'h0;
    return x;
  endfunction
  task automatic print_verdict();
    $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial
  begin
    logic [3:0]  x, r;
    logic [1:0]  e, c;
    logic [7:0]  s;
    logic [4:0]  t;
    logic [31:0] g, w;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(SUBST_BASE, 32'h0);
    rd_chk(SUBST_LAST, 32'h0);
    rd_chk(12'h3BF, 32'h0);
    wr_reg(12'h3E0, 32'hFF);
    rd_chk(12'h3E0, 32'h0);
    wr_reg(SUBST_LAST, 32'hFFFF_FFFF);
    rd_chk(SUBST_LAST, 32'h7F);
    for (int i = 0; i < 16; i++)
    begin
      e = 2'(i);
      c = 2'(i >> 2);
      t = 5'(2 * i + 1);
      r = 4'(i) ^ 4'hA;
      s = 8'(i * 37);
      wr_reg(SUBST_BASE + 12'(t), {24'h0, s});
      wr_reg(CFG_BASE + 12'(t), {27'h0, i[0], c, e});
      rd_chk(SUBST_BASE + 12'(t), {25'h0, s[6:0]});
      rd_chk(CFG_BASE + 12'(t), {27'h0, i[0], c, e});
      x = exp_sig(r, e, c, s);
      send(t, r);
      g = {21'h0, ovalid, ooh, oslot, odata};
      w = {21'h0, 1'b1, i[0], t, x};
      if (e == EXT_NONE) g[8:0] = 9'h0;
      if (e == EXT_NONE) w = 32'h0;
      cmp(g, w);
      rd_chk(ARRAY_BASE + 12'(t), {28'h0, w[3:0]});
    end
    print_verdict();
  end
  // whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
